//--- logic/bfs_breaker_failure_monitor.sv
`timescale 1ns/1ps
module bfs_breaker_failure_monitor
   import bfs_pkg::*;
#(
   parameter int TICK_CYCLES = BFS_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // breaker-mapped trips, extra trigger inputs and breaker position, asynchronous pins
   input wire logic mapped_external_trip,
   input wire logic mapped_current_trip,
   input wire logic mapped_other_trip,
   input wire logic extra_trigger_input_a,
   input wire logic extra_trigger_input_b,
   input wire logic extra_trigger_input_c,
   input wire logic breaker_open_position,
   // measured current from the same clock domain
   input wire logic [15:0] measured_current,
   // outputs
   output logic backup_trip,
   output logic lockout
);
   // ==========================================================
   // input synchronisers
   logic [BFS_SYNC_W-1:0] pin_raw;
   logic [BFS_SYNC_W-1:0] sync_a;
   logic [BFS_SYNC_W-1:0] sync_b;

   // bit 6 position pin, bits 5..3 extra inputs, bits 2..0 mapped trips
   assign pin_raw = {breaker_open_position, extra_trigger_input_c, extra_trigger_input_b,
                     extra_trigger_input_a, mapped_other_trip, mapped_current_trip,
                     mapped_external_trip};

   // two flip-flops per pin
   genvar gi;
   generate
      for (gi = 0; gi < BFS_SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end
            else
            begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   // synchronised pin levels, only the second stage is read
   wire ext_trip = sync_b[0];
   wire cur_trip = sync_b[1];
   wire oth_trip = sync_b[2];
   wire extra_any = |sync_b[5:3]; // mapping plays no part here
   wire pos_open = sync_b[6];

   // ==========================================================
   // configuration registers
   // control word, four parameter sets, acknowledge strobe
   logic [5:0] ctrl;
   logic [15:0] thr_set [BFS_NUM_SETS];
   logic [15:0] time_set [BFS_NUM_SETS];
   logic ack_pulse;

   // fields of the control word
   wire bfs_scheme_e scheme = bfs_scheme_e'(ctrl[BFS_CTRL_SCHEME_LSB +: 2]);
   wire bfs_trig_e trig_mode = bfs_trig_e'(ctrl[BFS_CTRL_TRIG_LSB +: 2]);
   wire [1:0] set_sel = ctrl[BFS_CTRL_SET_LSB +: 2];

   // values of the active parameter set
   wire [15:0] act_thr = thr_set[set_sel]; // active parameter set
   wire [15:0] act_time = time_set[set_sel];

   // ==========================================================
   // apb decode
   wire setup = psel && !penable;
   wire access = psel && penable;
   // address decode, one word per register
   wire hit_ctrl = (paddr == BFS_OFS_CTRL);
   wire hit_stat = (paddr == BFS_OFS_STATUS);
   wire hit_ack = (paddr == BFS_OFS_ACK);
   wire hit_thr = (paddr[7:4] == BFS_OFS_THR_BASE[7:4]) && (paddr[1:0] == 2'b00);
   wire hit_time = (paddr[7:4] == BFS_OFS_TIME_BASE[7:4]) && (paddr[1:0] == 2'b00);
   wire [1:0] set_idx = paddr[3:2];

   // any register hit, and the write strobe of the access phase
   wire mapped = hit_ctrl || hit_stat || hit_ack || hit_thr || hit_time;
   wire wr_en = access && pwrite && mapped;

   // zero wait states; unmapped accesses flagged and ignored
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // one-cycle acknowledge strobe for the lockout
   assign ack_pulse = wr_en && hit_ack && pwdata[BFS_ACK_BIT];

   // control register write
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl <= BFS_RST_CTRL;
      else if (wr_en && hit_ctrl)
         ctrl <= pwdata[5:0];
   end

   // parameter sets, one generate entry per set
   generate
      for (gi = 0; gi < BFS_NUM_SETS; gi++)
      begin : g_set
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               thr_set[gi] <= BFS_RST_THR;
               time_set[gi] <= BFS_RST_TIME;
            end
            else if (wr_en && set_idx == 2'(gi))
            begin
               if (hit_thr)
                  thr_set[gi] <= pwdata[15:0];
               if (hit_time)
                  time_set[gi] <= pwdata[15:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // trigger selection
   // mapped trips picked by the trigger mode, every mode decoded
   logic mapped_sel;
   always_comb
   begin
      unique case (trig_mode)
         BFS_TRIG_NONE: mapped_sel = 1'b0;
         BFS_TRIG_ALL: mapped_sel = ext_trip || cur_trip || oth_trip;
         BFS_TRIG_EXTERNAL: mapped_sel = ext_trip;
         BFS_TRIG_CURRENT: mapped_sel = cur_trip;
      endcase
   end

   // extra inputs count in every mode
   wire trigger = mapped_sel || extra_any;

   // ==========================================================
   // opening detection and failure decision
   // current below the active threshold
   wire cur_low = (measured_current < act_thr);

   // opening seen, and failure verdict should the timer run out
   logic opened;
   logic fail_at_expiry;
   always_comb
   begin
      unique case (scheme)
         BFS_SCHEME_CURRENT:
         begin
            opened = cur_low;
            fail_at_expiry = !cur_low;
         end
         BFS_SCHEME_POSITION:
         begin
            opened = pos_open;
            fail_at_expiry = !pos_open;
         end
         // both upper codes mean the combined scheme
         BFS_SCHEME_COMBINED, BFS_SCHEME_COMBINED_ALT:
         begin
            opened = cur_low && pos_open;
            fail_at_expiry = !cur_low && !pos_open;
         end
      endcase
   end
   // breaker already open with current low blocks pickup
   wire pickup_block = cur_low && pos_open;

   // ==========================================================
   // supervision timer
   // timer link and state register
   bfs_tmr_if tif ();
   bfs_state_e state;
   bfs_state_e next_state;
   wire in_standby = (state == BFS_ST_STANDBY);
   wire in_running = (state == BFS_ST_RUNNING);

   // tick prescaler and tick counter
   bfs_sup_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .tif(tif)
   );

   // limit from the active parameter set
   assign tif.limit = act_time; // counted in ticks
   // start only from stand-by with nothing seen open
   assign tif.start = in_standby && trigger && !pickup_block && !opened;
   // no stop in the start cycle: stop has priority inside the timer
   assign tif.stop = !tif.start && (!in_running || opened);

   // ==========================================================
   // state sequence
   // next state from trigger, opening and expiry
   always_comb
   begin
      next_state = state;
      unique case (state)
         BFS_ST_STANDBY:
         begin
            // breaker already shown open: nothing to supervise
            if (trigger && (opened || pos_open))
               next_state = BFS_ST_REJECTED;
            else if (tif.start)
               next_state = BFS_ST_RUNNING;
         end
         BFS_ST_RUNNING:
         begin
            // trigger level ignored while counting
            if (opened)
               next_state = trigger ? BFS_ST_REJECTED : BFS_ST_STANDBY;
            else if (tif.expired && fail_at_expiry)
               next_state = BFS_ST_TRIPPED;
            // expiry in the combined scheme with only one of current low and position open
            else if (tif.expired)
               next_state = trigger ? BFS_ST_REJECTED : BFS_ST_STANDBY;
         end
         BFS_ST_TRIPPED:
         begin
            // trip stands while any trigger remains
            if (!trigger)
               next_state = BFS_ST_STANDBY;
         end
         BFS_ST_REJECTED:
         begin
            // rejected until the triggers fall back
            if (!trigger)
               next_state = BFS_ST_STANDBY;
         end
      endcase
   end

   // trip level and its rising edge
   wire next_trip = (next_state == BFS_ST_TRIPPED);
   wire trip_rise = next_trip && (state != BFS_ST_TRIPPED);

   // state register
   always_ff @(posedge clk)
   begin
      if (!rstn)
         state <= BFS_ST_STANDBY;
      else
         state <= next_state;
   end

   // backup trip follows the tripped state
   always_ff @(posedge clk)
   begin
      if (!rstn)
         backup_trip <= 1'b0;
      else
         backup_trip <= next_trip;
   end

   // lockout latch, set wins over a same-cycle acknowledge
   always_ff @(posedge clk)
   begin
      if (!rstn)
         lockout <= 1'b0;
      else if (trip_rise)
         lockout <= 1'b1;
      else if (ack_pulse)
         lockout <= 1'b0;
   end

   // ==========================================================
   // read data, captured in the setup cycle
   // read selection, unmapped and write-only words read zero
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      if (hit_ctrl)
         rd_mux = {26'h000_0000, ctrl};
      // status: state, trip, lockout, effective trigger
      else if (hit_stat)
      begin
         rd_mux[BFS_STAT_STATE_LSB +: 2] = state;
         rd_mux[BFS_STAT_TRIP_BIT] = backup_trip;
         rd_mux[BFS_STAT_LOCK_BIT] = lockout;
         rd_mux[BFS_STAT_TRIG_BIT] = trigger;
      end
      else if (hit_thr)
         rd_mux = {16'h0000, thr_set[set_idx]};
      else if (hit_time)
         rd_mux = {16'h0000, time_set[set_idx]};
   end

   // read data register, held through the access phase
   always_ff @(posedge clk)
   begin
      if (!rstn)
         prdata <= '0;
      else if (setup && !pwrite)
         prdata <= rd_mux;
   end
endmodule : bfs_breaker_failure_monitor

//--- logic/bfs_pkg.sv
// ==========================================================
// shared constants for the breaker failure monitor
package bfs_pkg;
   // register byte offsets
   localparam logic [7:0] BFS_OFS_CTRL = 8'h00;
   localparam logic [7:0] BFS_OFS_STATUS = 8'h04;
   localparam logic [7:0] BFS_OFS_ACK = 8'h08;
   localparam logic [7:0] BFS_OFS_THR_BASE = 8'h10;
   localparam logic [7:0] BFS_OFS_TIME_BASE = 8'h20;
   // control field positions
   localparam int BFS_CTRL_SCHEME_LSB = 0;
   localparam int BFS_CTRL_TRIG_LSB = 2;
   localparam int BFS_CTRL_SET_LSB = 4;
   // status field positions
   localparam int BFS_STAT_STATE_LSB = 0;
   localparam int BFS_STAT_TRIP_BIT = 2;
   localparam int BFS_STAT_LOCK_BIT = 3;
   localparam int BFS_STAT_TRIG_BIT = 4;
   localparam int BFS_ACK_BIT = 0;
   // widths and counts
   localparam int BFS_NUM_SETS = 4;
   localparam int BFS_VAL_W = 16;
   localparam int BFS_SYNC_W = 7;
   // reset values
   localparam logic [15:0] BFS_RST_THR = 16'h0100;
   localparam logic [15:0] BFS_RST_TIME = 16'h0064;
   localparam logic [5:0] BFS_RST_CTRL = 6'h05;
   // timebase: one supervision tick per millisecond
   localparam int BFS_CLK_PERIOD_NS = 25;
   localparam int BFS_TICK_PERIOD_NS = 1000000;
   localparam int BFS_TICK_CYCLES = BFS_TICK_PERIOD_NS / BFS_CLK_PERIOD_NS;

   typedef enum logic [1:0]
   {
      BFS_SCHEME_CURRENT = 2'b00,
      BFS_SCHEME_POSITION = 2'b01,
      BFS_SCHEME_COMBINED = 2'b10,
      BFS_SCHEME_COMBINED_ALT = 2'b11
   } bfs_scheme_e;

   typedef enum logic [1:0]
   {
      BFS_TRIG_NONE = 2'b00,
      BFS_TRIG_ALL = 2'b01,
      BFS_TRIG_EXTERNAL = 2'b10,
      BFS_TRIG_CURRENT = 2'b11
   } bfs_trig_e;

   typedef enum logic [1:0]
   {
      BFS_ST_STANDBY = 2'b00,
      BFS_ST_RUNNING = 2'b01,
      BFS_ST_TRIPPED = 2'b11,
      BFS_ST_REJECTED = 2'b10
   } bfs_state_e;
endpackage : bfs_pkg

//--- logic/bfs_tmr_if.sv
`timescale 1ns/1ps
// ==========================================================
// link between the supervisor and its supervision timer
interface bfs_tmr_if;
   logic start;
   logic stop;
   logic [15:0] limit;
   logic expired;
   logic running;
   modport ctl (output start, output stop, output limit, input expired, input running);
   modport tmr (input start, input stop, input limit, output expired, output running);
endinterface : bfs_tmr_if

//--- logic/bfs_sup_timer.sv
`timescale 1ns/1ps
// ==========================================================
// supervision timer counting whole timebase ticks
module bfs_sup_timer
   import bfs_pkg::*;
#(
   parameter int TICK_CYCLES = BFS_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rstn,
   bfs_tmr_if.tmr tif
);
   logic [31:0] prescale;
   logic [15:0] ticks;
   logic running;
   wire tick = (prescale == 32'(TICK_CYCLES - 1));

   // prescaler restarts with each start so the first tick is a full one
   always_ff @(posedge clk)
   begin
      if (!rstn || tif.start || tick)
         prescale <= '0;
      else
         prescale <= prescale + 32'h0000_0001;
   end

   // tick count, kept running regardless of the trigger level
   always_ff @(posedge clk)
   begin
      if (!rstn || tif.stop)
      begin
         running <= 1'b0;
         ticks <= '0;
      end
      else if (tif.start)
      begin
         running <= 1'b1;
         ticks <= '0;
      end
      else if (running && tick && ticks != tif.limit)
         ticks <= ticks + 16'h0001;
   end

   assign tif.running = running;
   assign tif.expired = running && (ticks == tif.limit);
endmodule : bfs_sup_timer

//--- tb/bfs_monitor_chk.sv
`timescale 1ns/1ps
// ==========================================================
// pin-level checks on the breaker failure supervisor
module bfs_monitor_chk
   import bfs_pkg::*;
#(
   parameter int TICK_CYCLES = BFS_TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic mapped_external_trip,
   input wire logic mapped_current_trip,
   input wire logic mapped_other_trip,
   input wire logic extra_trigger_input_a,
   input wire logic extra_trigger_input_b,
   input wire logic extra_trigger_input_c,
   input wire logic breaker_open_position,
   input wire logic backup_trip,
   input wire logic lockout
);
   logic ack_wr;
   logic ext_any;
   logic trig_any;
   logic [1:0] scheme_q;
   // acknowledge strobe and trigger pin summaries
   assign ack_wr = psel && penable && pwrite && paddr == BFS_OFS_ACK && pwdata[BFS_ACK_BIT];
   assign ext_any = extra_trigger_input_a || extra_trigger_input_b || extra_trigger_input_c;
   assign trig_any = ext_any || mapped_external_trip || mapped_current_trip || mapped_other_trip;
   // shadow of the scheme field, so position checks know when they apply
   always_ff @(posedge clk)
   begin
      if (!rstn)
         scheme_q <= BFS_RST_CTRL[1:0];
      else if (psel && penable && pwrite && paddr == BFS_OFS_CTRL)
         scheme_q <= pwdata[1:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence quiet_s; !trig_any [*6]; endsequence
   sequence ext_held_s; ext_any [*3]; endsequence
   sequence open_held_s; breaker_open_position [*4]; endsequence
   trip_lock_a: assert property ($rose(backup_trip) |-> lockout)
      else $error("lockout missing with backup trip");
   lock_src_a: assert property ($rose(lockout) |-> $rose(backup_trip))
      else $error("lockout rose without backup trip");
   lock_hold_a: assert property (lockout && !ack_wr |=> lockout)
      else $error("lockout dropped without acknowledge");
   lock_clear_a: assert property (ack_wr |=> !lockout || $rose(backup_trip))
      else $error("lockout kept after acknowledge");
   idle_clear_a: assert property (quiet_s ##0 backup_trip |=> !backup_trip)
      else $error("backup trip kept with all triggers low");
   reset_clear_a: assert property ($rose(rstn) |-> !backup_trip && !lockout)
      else $error("outputs not cleared by reset");
   open_no_trip_a: assert property ((scheme_q != 2'b00) throughout open_held_s
      |-> !$rose(backup_trip)) else $error("trip with breaker shown open");
   trip_stands_a: assert property (ext_held_s ##0 backup_trip |=> backup_trip)
      else $error("backup trip dropped while triggered");
endmodule : bfs_monitor_chk

bind bfs_breaker_failure_monitor bfs_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) bfs_monitor_chk_inst (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .mapped_external_trip(mapped_external_trip),
   .mapped_current_trip(mapped_current_trip), .mapped_other_trip(mapped_other_trip),
   .extra_trigger_input_a(extra_trigger_input_a), .extra_trigger_input_b(extra_trigger_input_b),
   .extra_trigger_input_c(extra_trigger_input_c), .breaker_open_position(breaker_open_position),
   .backup_trip(backup_trip), .lockout(lockout));

//--- tb/bfs_field_model.sv
`timescale 1ns/1ps
// ==========================================================
// fault current and breaker; the breaker needs time to open
module bfs_field_model #(
   parameter int OPEN_DLY = 8
)
(
   input wire logic clk,
   input wire logic open_cmd,
   input wire logic [15:0] fault_current,
   output logic breaker_open_position,
   output logic [15:0] measured_current
);
   int cnt = 0;
   // no current flows once the contacts have parted
   assign measured_current = breaker_open_position ? 16'h0000 : fault_current;
   // position follows the command only after the operating time
   initial breaker_open_position = 1'b0;
   always @(posedge clk)
   begin
      cnt <= (open_cmd != breaker_open_position) ? cnt + 1 : 0;
      if (cnt == OPEN_DLY)
         breaker_open_position <= open_cmd;
   end
endmodule : bfs_field_model

//--- tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (x)); end end
// ==========================================================
// register and pin level tests of the supervisor
module testbench
   import bfs_pkg::*;
;
   logic clk = 0;
   logic rstn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic backup_trip;
   logic lockout;
   logic bpos;
   logic [5:0] trip_cmd = 0;
   logic open_cmd = 0;
   logic [15:0] cur_cmd = 0;
   logic [15:0] cur;
   logic [31:0] q;
   logic e;
   int n_errors = 0;
   int num_checks = 0;
   initial forever #12.5 clk = ~clk;
   bfs_breaker_failure_monitor #(.TICK_CYCLES(4)) bfs_breaker_failure_monitor_inst (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mapped_external_trip(trip_cmd[0]), .mapped_current_trip(trip_cmd[1]),
      .mapped_other_trip(trip_cmd[2]), .extra_trigger_input_a(trip_cmd[3]),
      .extra_trigger_input_b(trip_cmd[4]), .extra_trigger_input_c(trip_cmd[5]),
      .breaker_open_position(bpos), .measured_current(cur), .backup_trip(backup_trip),
      .lockout(lockout));
   bfs_field_model bfs_field_model_inst (.clk(clk), .open_cmd(open_cmd),
      .fault_current(cur_cmd), .breaker_open_position(bpos), .measured_current(cur));
   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(q, x)
   endtask : rd
   // one fault: trigger, let the timer run out, then clear and acknowledge
   task automatic run(input logic [5:0] ctrl, input logic [5:0] cmd, input logic op,
      input logic [15:0] c, input int hold, input logic [4:0] x);
      apb(1'b1, BFS_OFS_CTRL, {26'h0, ctrl});
      trip_cmd <= cmd;
      open_cmd <= op;
      cur_cmd <= c;
      repeat (hold) @(posedge clk);
      if (hold < 40)
         trip_cmd <= 6'h00;
      repeat (40 - hold) @(posedge clk);
      rd(BFS_OFS_STATUS, {27'h0, x});
      `CHK(backup_trip, x[2])
      `CHK(lockout, x[3])
      trip_cmd <= 6'h00;
      repeat (6) @(posedge clk);
      `CHK(backup_trip, 1'b0)
      `CHK(lockout, x[3])
      apb(1'b1, BFS_OFS_ACK, 32'h0000_0001);
      @(posedge clk);
      `CHK(lockout, 1'b0)
      open_cmd <= 1'b0;
      repeat (12) @(posedge clk);
   endtask : run
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   // reset, register defaults, then faults in every trigger mode and scheme
   initial
   begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd(BFS_OFS_CTRL, 32'h0000_0005);
      rd(BFS_OFS_STATUS, 32'h0000_0000);
      rd(BFS_OFS_THR_BASE + 8'h08, 32'h0000_0100);
      rd(BFS_OFS_TIME_BASE + 8'h0c, 32'h0000_0064);
      apb(1'b0, 8'h40, 32'h0000_0000);
      `CHK(e, 1'b1)
      apb(1'b1, BFS_OFS_TIME_BASE + 8'h04, 32'h0000_0006);
      apb(1'b1, BFS_OFS_THR_BASE + 8'h04, 32'h0000_0200);
      apb(1'b1, BFS_OFS_TIME_BASE + 8'h08, 32'h0000_0006);
      apb(1'b1, BFS_OFS_THR_BASE + 8'h08, 32'h0000_ffff);
      run(6'h10, 6'h08, 1'b0, 16'h0300, 40, 5'h1f);
      run(6'h10, 6'h10, 1'b1, 16'h0300, 40, 5'h12);
      run(6'h15, 6'h04, 1'b0, 16'h0000, 40, 5'h1f);
      run(6'h11, 6'h08, 1'b1, 16'h0000, 40, 5'h12);
      run(6'h19, 6'h02, 1'b0, 16'h0000, 40, 5'h00);
      run(6'h19, 6'h01, 1'b0, 16'h0000, 40, 5'h1f);
      run(6'h1c, 6'h02, 1'b0, 16'h0300, 40, 5'h1f);
      run(6'h1c, 6'h01, 1'b0, 16'h0300, 40, 5'h00);
      run(6'h10, 6'h07, 1'b0, 16'h0300, 40, 5'h00);
      run(6'h12, 6'h20, 1'b0, 16'h0000, 40, 5'h12);
      run(6'h12, 6'h20, 1'b0, 16'h0300, 40, 5'h1f);
      run(6'h13, 6'h20, 1'b0, 16'h0300, 40, 5'h1f);
      run(6'h10, 6'h08, 1'b0, 16'h0300, 8, 5'h08);
      run(6'h20, 6'h08, 1'b0, 16'h0300, 40, 5'h12);
      end_sim();
   end
   // hang guard, several times the expected run length
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule : testbench
